// [pcer_regs.vh]
/*
 Register offsets, field positions, reset values and mask bits for the
 per-channel event status bank.
 Assumes it is included by bare name and defines nothing else.
*/
`ifndef PCER_REGS_VH
`define PCER_REGS_VH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PCER_CMD_PWR_VIEW    8'h02
`define PCER_CMD_PWR_CLR     8'h03
`define PCER_CMD_DET_VIEW    8'h04
`define PCER_CMD_DET_CLR     8'h05
`define PCER_CMD_FLT_VIEW    8'h06
`define PCER_CMD_FLT_CLR     8'h07
`define PCER_CMD_STL_VIEW    8'h08
`define PCER_CMD_STL_CLR     8'h09

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define PCER_HI_MSB          7
`define PCER_HI_LSB          4
`define PCER_LO_MSB          3
`define PCER_LO_LSB          0
`define PCER_EVT_RESET       8'h00
`define PCER_MASK_RESET      8'h80
`define PCER_UNMAPPED_DATA   8'h00

// ----------------------------------------------------------------------
// Interrupt mask bit positions
// ----------------------------------------------------------------------
`define PCER_MSK_START       6
`define PCER_MSK_FAULT       5
`define PCER_MSK_CLASS       4
`define PCER_MSK_DETECT      3
`define PCER_MSK_DISC        2
`define PCER_MSK_PEN         0

`endif

// [pcer_chg_det.v]
/*
 One change-only event qualifier for one channel and one result type.
 Assumes result and done strobe are synchronous to the clock.
*/
`timescale 1ns/1ps
module pcer_chg_det (
	input  wire       clk,
	input  wire       rst,
	input  wire       done,
	input  wire [3:0] result,
	input  wire       change_only,
	output wire       event_out
);
	reg [3:0] last_r;
	reg       seen_r;

	// Changed means differs from the last completed cycle
	assign event_out = done & (~change_only | ~seen_r |
		(result != last_r));

	always @(posedge clk) begin
		if (rst) begin
			last_r <= 4'h0;
			seen_r <= 1'b0;
		end else if (done) begin
			last_r <= result;
			seen_r <= 1'b1;
		end
	end
endmodule

// [pcer_evt_byte.v]
/*
 One byte-wide event register: per-bit sticky set, clearing read,
 and per-channel clear on turn-off.
 Assumes set pulses and clear strobes are synchronous to the clock.
*/
`timescale 1ns/1ps
`include "pcer_regs.vh"
module pcer_evt_byte (
	input  wire       clk,
	input  wire       rst,
	input  wire [7:0] set_bits,
	input  wire       read_clear,
	input  wire [3:0] chan_off,
	output reg  [7:0] value_r
);
	wire [7:0] off_mask;
	assign off_mask = {chan_off, chan_off};

	always @(posedge clk) begin
		if (rst)
			value_r <= `PCER_EVT_RESET;
		else
			// Set wins over any clear in the same cycle
			value_r <= (value_r & ~off_mask & {8{~read_clear}}) |
				set_bits;
	end
endmodule

// [pcer_event_bank.v]
/*
 Per-channel event status bank of a four-channel power-sourcing group.
 Assumes the command interface decodes one read per cycle that RD_STB is high,
 and that channel event pulses are synchronous one-cycle strobes.
*/
`timescale 1ns/1ps
`include "pcer_regs.vh"
module pcer_event_bank (
	input  wire        SYS_CLK,
	input  wire        RST,
	input  wire        RD_STB,
	input  wire [7:0]  RD_CMD,
	input  wire [7:0]  IRQ_MASK,
	input  wire        CLASS_CHANGE_ONLY_OPTION,
	input  wire        DETECT_CHANGE_ONLY_OPTION,
	input  wire        AUTO_MODE,
	input  wire [3:0]  CLASS_DONE,
	input  wire [15:0] CLASS_RESULT,
	input  wire [3:0]  DETECT_DONE,
	input  wire [15:0] DETECT_RESULT,
	input  wire [3:0]  DISCONNECT_EVT,
	input  wire [3:0]  OVERLOAD_EXPIRED,
	input  wire [3:0]  LIMIT_EXPIRED,
	input  wire [3:0]  START_TIME_FAULT,
	input  wire [3:0]  DISCOVERY_ERROR,
	input  wire [3:0]  CHAN_ENABLED,
	input  wire [3:0]  CHAN_OFF,
	output reg  [7:0]  RD_DATA,
	output reg         RD_VALID,
	output reg  [3:0]  POWER_ENABLE_CHANGE_FLAG,
	output reg  [3:0]  POWER_ON_FAULT_LOG,
	output reg  [3:0]  TURN_ON_FAULT_CAUSE,
	output reg         INT_N
);
	// ------------------------------------------------------------------
	// Event qualification
	// ------------------------------------------------------------------
	wire [3:0] class_event_flags;
	wire [3:0] detect_event_flags;
	wire [3:0] turn_on_fault_flags;
	wire [3:0] start_evt;
	wire [3:0] pen_change;
	reg  [3:0] pen_prev_r;
	reg  [3:0] pen_flag_nxt;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			pcer_chg_det u_cls (
				.clk         (SYS_CLK),
				.rst         (RST),
				.done        (CLASS_DONE[g]),
				.result      (CLASS_RESULT[4*g+3:4*g]),
				.change_only (CLASS_CHANGE_ONLY_OPTION),
				.event_out   (class_event_flags[g])
			);
			pcer_chg_det u_det (
				.clk         (SYS_CLK),
				.rst         (RST),
				.done        (DETECT_DONE[g]),
				.result      (DETECT_RESULT[4*g+3:4*g]),
				.change_only (DETECT_CHANGE_ONLY_OPTION),
				.event_out   (detect_event_flags[g])
			);
		end
	endgenerate

	// Invalid discovery does not count as a start fault in auto mode
	assign start_evt = START_TIME_FAULT |
		(DISCOVERY_ERROR & {4{~AUTO_MODE}});
	assign turn_on_fault_flags = start_evt;
	assign pen_change = CHAN_ENABLED ^ pen_prev_r;

	// ------------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------------
	wire clr_det;
	wire clr_flt;
	wire clr_stl;
	wire clr_pwr;
	assign clr_det = RD_STB & (RD_CMD == `PCER_CMD_DET_CLR);
	assign clr_flt = RD_STB & (RD_CMD == `PCER_CMD_FLT_CLR);
	assign clr_stl = RD_STB & (RD_CMD == `PCER_CMD_STL_CLR);
	assign clr_pwr = RD_STB & (RD_CMD == `PCER_CMD_PWR_CLR);

	// ------------------------------------------------------------------
	// Event registers
	// ------------------------------------------------------------------
	wire [7:0] det_r;
	wire [7:0] flt_r;
	wire [7:0] stl_r;

	pcer_evt_byte u_det_byte (
		.clk        (SYS_CLK),
		.rst        (RST),
		.set_bits   ({class_event_flags, detect_event_flags}),
		.read_clear (clr_det),
		.chan_off   (CHAN_OFF),
		.value_r    (det_r)
	);

	// Overload counters live outside; clearing here never touches them
	pcer_evt_byte u_flt_byte (
		.clk        (SYS_CLK),
		.rst        (RST),
		.set_bits   ({DISCONNECT_EVT, OVERLOAD_EXPIRED}),
		.read_clear (clr_flt),
		.chan_off   (CHAN_OFF),
		.value_r    (flt_r)
	);

	pcer_evt_byte u_stl_byte (
		.clk        (SYS_CLK),
		.rst        (RST),
		.set_bits   ({LIMIT_EXPIRED, turn_on_fault_flags}),
		.read_clear (clr_stl),
		.chan_off   (CHAN_OFF),
		.value_r    (stl_r)
	);

	// ------------------------------------------------------------------
	// Power-enable change flags and power-on fault log
	// ------------------------------------------------------------------
	always @* begin
		pen_flag_nxt = POWER_ENABLE_CHANGE_FLAG & {4{~clr_pwr}};
		pen_flag_nxt = pen_flag_nxt | pen_change;
	end

	always @(posedge SYS_CLK) begin
		if (RST) begin
			pen_prev_r               <= 4'h0;
			POWER_ENABLE_CHANGE_FLAG <= 4'h0;
			POWER_ON_FAULT_LOG       <= 4'h0;
			TURN_ON_FAULT_CAUSE      <= 4'h0;
		end else begin
			pen_prev_r               <= CHAN_ENABLED;
			POWER_ENABLE_CHANGE_FLAG <= pen_flag_nxt;
			// Non-inrush start faults record their cause
			POWER_ON_FAULT_LOG <= POWER_ON_FAULT_LOG |
				(start_evt & ~pen_flag_nxt);
			TURN_ON_FAULT_CAUSE <= (TURN_ON_FAULT_CAUSE &
				~start_evt) | (START_TIME_FAULT & ~pen_flag_nxt);
		end
	end

	// ------------------------------------------------------------------
	// Read data and interrupt
	// ------------------------------------------------------------------
	reg [7:0] rd_nxt;
	always @* begin
		case (RD_CMD)
		`PCER_CMD_DET_VIEW, `PCER_CMD_DET_CLR: rd_nxt = det_r;
		`PCER_CMD_FLT_VIEW, `PCER_CMD_FLT_CLR: rd_nxt = flt_r;
		`PCER_CMD_STL_VIEW, `PCER_CMD_STL_CLR: rd_nxt = stl_r;
		`PCER_CMD_PWR_VIEW, `PCER_CMD_PWR_CLR:
			rd_nxt = {4'h0, POWER_ENABLE_CHANGE_FLAG};
		default: rd_nxt = `PCER_UNMAPPED_DATA;
		endcase
	end

	// Interrupt follows the post-update bits, so a clearing read
	// releases it one cycle after the read strobe
	wire [3:0] det_live;
	wire [3:0] cls_live;
	wire [3:0] flt_lo;
	wire [3:0] flt_hi;
	wire [3:0] stl_hi;
	wire [3:0] stl_lo;
	wire       irq_any;
	assign cls_live = det_r[`PCER_HI_MSB:`PCER_HI_LSB];
	assign det_live = det_r[`PCER_LO_MSB:`PCER_LO_LSB];
	assign flt_hi   = flt_r[`PCER_HI_MSB:`PCER_HI_LSB];
	assign flt_lo   = flt_r[`PCER_LO_MSB:`PCER_LO_LSB];
	assign stl_hi   = stl_r[`PCER_HI_MSB:`PCER_HI_LSB];
	assign stl_lo   = stl_r[`PCER_LO_MSB:`PCER_LO_LSB];
	assign irq_any =
		(IRQ_MASK[`PCER_MSK_CLASS]  & (|cls_live)) |
		(IRQ_MASK[`PCER_MSK_DETECT] & (|det_live)) |
		(IRQ_MASK[`PCER_MSK_DISC]   & (|flt_hi)) |
		(IRQ_MASK[`PCER_MSK_FAULT]  & (|(flt_lo | stl_hi))) |
		(IRQ_MASK[`PCER_MSK_START]  & (|stl_lo)) |
		(IRQ_MASK[`PCER_MSK_PEN]    & (|POWER_ENABLE_CHANGE_FLAG));

	always @(posedge SYS_CLK) begin
		if (RST) begin
			RD_DATA  <= 8'h00;
			RD_VALID <= 1'b0;
			INT_N    <= 1'b1;
		end else begin
			RD_VALID <= RD_STB;
			if (RD_STB)
				RD_DATA <= rd_nxt;
			INT_N <= ~irq_any;
		end
	end
endmodule

// [pcer_event_bank_sva.sv]
/* Port checker for the event bank.
 Assumes it is bound to pcer_event_bank and sees only its ports. */
`timescale 1ns/1ps
module pcer_sva (
	input wire       SYS_CLK,
	input wire       RST,
	input wire       RD_STB,
	input wire [7:0] RD_CMD,
	input wire [7:0] IRQ_MASK,
	input wire [3:0] CLASS_DONE,
	input wire [3:0] DETECT_DONE,
	input wire [3:0] DISCONNECT_EVT,
	input wire [3:0] OVERLOAD_EXPIRED,
	input wire [3:0] CHAN_OFF,
	input wire [7:0] RD_DATA,
	input wire       RD_VALID,
	input wire       INT_N
);
	// ----------------------------
	// Properties
	// ----------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	// Set wins over clears, so clear checks need a cycle without events
	// A channel turn-off also clears bits, so it is kept out too
	wire quiet = (CLASS_DONE == 4'h0) && (DETECT_DONE == 4'h0) &&
		(CHAN_OFF == 4'h0);
	sequence s_rd(c); RD_STB && (RD_CMD == c); endsequence
	sequence s_clr; s_rd(8'h05) ##0 quiet ##0 (IRQ_MASK == 8'h08); endsequence
	property p_ans; RD_STB |=> RD_VALID; endproperty
	property p_idle; !RD_STB |=> !RD_VALID; endproperty
	property p_clr; s_rd(8'h05) ##0 quiet ##1 s_rd(8'h04) |=> RD_DATA == 8'h00;
	endproperty
	property p_keep; s_rd(8'h04) ##0 quiet ##1 s_rd(8'h04) |=> $stable(RD_DATA);
	endproperty
	property p_unmap; (RD_STB && RD_CMD > 8'h09) |=> RD_DATA == 8'h00;
	endproperty
	property p_mask0; (IRQ_MASK == 8'h00) [*2] |=> INT_N; endproperty
	property p_rel; s_clr ##1 (IRQ_MASK == 8'h08) |=> INT_N; endproperty
	property p_disc; (DISCONNECT_EVT != 4'h0 && CHAN_OFF == 4'h0)
		##1 (IRQ_MASK[2] && CHAN_OFF == 4'h0) |=> !INT_N; endproperty
	property p_off; (CHAN_OFF[1] && !DISCONNECT_EVT[1] && !OVERLOAD_EXPIRED[1])
		##1 s_rd(8'h06) |=> !RD_DATA[5] && !RD_DATA[1]; endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	a_idle: assert property (p_idle) else $error("stray valid");
	a_clr: assert property (p_clr) else $error("not cleared");
	a_keep: assert property (p_keep) else $error("view changed");
	a_unmap: assert property (p_unmap) else $error("unmapped data");
	a_mask0: assert property (p_mask0) else $error("masked irq");
	a_rel: assert property (p_rel) else $error("irq held");
	a_disc: assert property (p_disc) else $error("irq missing");
	a_off: assert property (p_off) else $error("off kept bits");
endmodule
bind pcer_event_bank pcer_sva chk (.SYS_CLK(SYS_CLK), .RST(RST),
	.RD_STB(RD_STB), .RD_CMD(RD_CMD), .IRQ_MASK(IRQ_MASK),
	.CLASS_DONE(CLASS_DONE), .DETECT_DONE(DETECT_DONE),
	.DISCONNECT_EVT(DISCONNECT_EVT), .OVERLOAD_EXPIRED(OVERLOAD_EXPIRED),
	.CHAN_OFF(CHAN_OFF), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
	.INT_N(INT_N));

// [pcer_host_model.sv]
/* Host model issuing command-coded reads at falling edges.
 Assumes the bank answers at the clock edge that takes the strobe. */
`timescale 1ns/1ps
module pcer_host_model (
	input  wire       clk,
	input  wire       rd_valid,
	input  wire [7:0] rd_data,
	output reg        rd_stb,
	output reg  [7:0] rd_cmd
);
	initial begin
		rd_stb = 1'b0;
		rd_cmd = 8'h00;
	end
	// Hold keeps the strobe up so the next read follows back to back
	task rd(input [7:0] c, input hold, output [7:0] q);
		begin
			if (!rd_stb)
				rd_stb = 1'b1;
			rd_cmd = c;
			@(negedge clk);
			q = (rd_valid === 1'b1) ? rd_data : 8'hXX;
			if (!hold) begin
				rd_stb = 1'b0;
				rd_cmd = ~c;
				@(negedge clk);
			end
		end
	endtask
endmodule

// [tb_pse_channel_event_registers.sv]
/* Scenario bench for the event bank.
 Assumes the host model for reads and one-cycle event pulses. */
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module tb_pse_channel_event_registers;
	localparam [3:0] Z = 4'h0;
	reg        clk = 1'b0, rst = 1'b1, copt = 1'b0, dopt = 1'b0, auto = 1'b0;
	reg  [7:0] mask = 8'h00, d;
	reg  [3:0] cls = Z, det = Z, dis = Z, ovl = Z, lim = Z, stf = Z;
	reg  [3:0] err = Z, off = Z, en = Z;
	reg [15:0] cres = 16'h0000, dres = 16'h0000;
	wire       stb, valid, int_n;
	wire [7:0] cmd, data;
	wire [3:0] pen, plog, cause;
	integer    error_cnt = 0, checks_done = 0;
	always #4 clk = ~clk;
	pcer_event_bank dut (.SYS_CLK(clk), .RST(rst), .RD_STB(stb), .RD_CMD(cmd),
		.IRQ_MASK(mask), .CLASS_CHANGE_ONLY_OPTION(copt),
		.DETECT_CHANGE_ONLY_OPTION(dopt), .AUTO_MODE(auto), .CLASS_DONE(cls),
		.CLASS_RESULT(cres), .DETECT_DONE(det), .DETECT_RESULT(dres),
		.DISCONNECT_EVT(dis), .OVERLOAD_EXPIRED(ovl), .LIMIT_EXPIRED(lim),
		.START_TIME_FAULT(stf), .DISCOVERY_ERROR(err), .CHAN_ENABLED(en),
		.CHAN_OFF(off), .RD_DATA(data), .RD_VALID(valid),
		.POWER_ENABLE_CHANGE_FLAG(pen), .POWER_ON_FAULT_LOG(plog),
		.TURN_ON_FAULT_CAUSE(cause), .INT_N(int_n));
	pcer_host_model host (.clk(clk), .rd_valid(valid), .rd_data(data),
		.rd_stb(stb), .rd_cmd(cmd));
	// ----------------------------
	// Helpers
	// ----------------------------
	task evt(input [3:0] c, e, s, o, l, f, r, x);
		begin
			{cls, det, dis, ovl, lim, stf, err, off} = {c, e, s, o, l, f, r, x};
			@(negedge clk);
			{cls, det, dis, ovl, lim, stf, err, off} = 32'h0000_0000;
		end
	endtask
	task rc(input [7:0] c, input [7:0] exp, input hold);
		begin
			host.rd(c, hold, d);
			`CHK(d, exp)
		end
	endtask
	task conclude;
		begin
			if (error_cnt == 0 && checks_done > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	// ----------------------------
	// Scenarios
	// ----------------------------
	task t_detect;
		begin
			evt(4'h1, 4'h8, Z, Z, Z, Z, Z, Z);
			repeat (3) @(negedge clk);
			`CHK(int_n, 1'b1)
			mask = 8'h10;
			repeat (3) @(negedge clk);
			`CHK(int_n, 1'b0)
			mask = 8'h08;
			rc(8'h04, 8'h18, 1);
			rc(8'h04, 8'h18, 0);
			rc(8'h05, 8'h18, 1);
			rc(8'h04, 8'h00, 0);
			`CHK(int_n, 1'b1)
		end
	endtask
	task t_change;
		begin
			{copt, dopt, cres, dres} = {2'b11, 16'h0030, 16'h0200};
			evt(4'h2, 4'h4, Z, Z, Z, Z, Z, Z);
			rc(8'h05, 8'h24, 0);
			evt(4'h2, 4'h4, Z, Z, Z, Z, Z, Z);
			rc(8'h05, 8'h00, 0);
			{cres, dres} = {16'h0050, 16'h0100};
			evt(4'h2, 4'h4, Z, Z, Z, Z, Z, Z);
			rc(8'h05, 8'h24, 0);
		end
	endtask
	task t_fault;
		begin
			mask = 8'h04;
			evt(Z, Z, 4'h2, 4'h4, Z, Z, Z, Z);
			rc(8'h06, 8'h24, 0);
			`CHK(int_n, 1'b0)
			evt(Z, Z, Z, Z, Z, Z, Z, 4'h2);
			rc(8'h06, 8'h04, 0);
			`CHK(int_n, 1'b1)
			rc(8'h07, 8'h04, 1);
			rc(8'h06, 8'h00, 0);
		end
	endtask
	task t_start;
		begin
			auto = 1'b1;
			evt(Z, Z, Z, Z, Z, Z, 4'h8, Z);
			rc(8'h08, 8'h00, 0);
			auto = 1'b0;
			evt(Z, Z, Z, Z, 4'h8, 4'h1, 4'h4, Z);
			rc(8'h09, 8'h85, 0);
			`CHK({plog, cause}, 8'h51)
			en = 4'h2;
			evt(Z, Z, Z, Z, Z, 4'h2, Z, Z);
			rc(8'h08, 8'h02, 0);
			// Enable change beside a start fault means inrush, no logged cause
			`CHK({pen, plog}, 8'h25)
		end
	endtask
	task t_mask;
		begin
			mask = 8'h40;
			repeat (2) @(negedge clk);
			`CHK(int_n, 1'b0)
			mask = 8'h01;
			repeat (2) @(negedge clk);
			`CHK(int_n, 1'b0)
			rc(8'h03, 8'h02, 1);
			rc(8'h02, 8'h00, 0);
			`CHK(int_n, 1'b1)
			{copt, dopt, mask} = {2'b00, 8'h20};
			evt(4'h2, 4'h2, Z, Z, 4'h2, Z, Z, Z);
			rc(8'h04, 8'h22, 0);
			rc(8'h08, 8'h22, 0);
			`CHK(int_n, 1'b0)
			evt(Z, Z, Z, Z, Z, Z, Z, 4'h2);
			rc(8'h04, 8'h00, 0);
			rc(8'h08, 8'h00, 0);
			`CHK(int_n, 1'b1)
		end
	endtask
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		for (int i = 4; i < 13; i += 4) rc(i[7:0], 8'h00, 0);
		t_detect;
		t_change;
		t_fault;
		t_start;
		t_mask;
		conclude;
	end
	initial begin
		#20000;
		error_cnt++;
		conclude;
	end
endmodule
